// *** core/lcg3_top.sv ***
/*
 * Gate 3 term select register, gate 3 OR combiner and the shared
 * cell output mirror register, reached over an APB slave port.
 * Assumes an APB master on clk, cell data inputs and cell outputs
 * synchronous to clk, and por_bor_nrst low only at power-on or
 * brown-out, with nrst held low alongside it.
 */
// Behaviour
// - Bit 7 gates input d true, bit 6 gates it inverted into gate 3
// - Bit 5 gates input c true, bit 4 gates it inverted into gate 3
// - Bit 3 gates input b true, bit 2 gates it inverted into gate 3
// - Bit 1 gates input a true, bit 0 gates it inverted into gate 3
// - Eight select bits read/write, cleared at power-on, kept over other resets
// - Mirror bits 3..0 copy cell 4..1 outputs, read only, reset to zero
// - Mirror bits 7..4 read zero and ignore writes
`timescale 1ns/1ps
`include "lcg3_regs.svh"
module lcg3_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic por_bor_nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire lcg3_pkg::lcg3_addr_t paddr,
  input wire lcg3_pkg::lcg3_data_t pwdata,
  input wire logic [3:0] pstrb,
  output lcg3_pkg::lcg3_data_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cell_data_in_a,
  input wire logic cell_data_in_b,
  input wire logic cell_data_in_c,
  input wire logic cell_data_in_d,
  input wire logic cell1_out,
  input wire logic cell2_out,
  input wire logic cell3_out,
  input wire logic cell4_out,
  output logic gate3_out,
  output logic [7:0] cell_gate3_terms,
  output logic mirror_cell1_out,
  output logic mirror_cell2_out,
  output logic mirror_cell3_out,
  output logic mirror_cell4_out
);
  import lcg3_pkg::*;

  localparam int NUM_IN = 4;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  lcg3_reg_e sel_reg;
  logic setup_ph;
  logic access_wr;
  logic [7:0] gate3_terms_r;
  logic [3:0] mirror_r;
  logic gate3_r;
  lcg3_data_t prdata_r;
  logic [NUM_IN-1:0] data_vec;
  logic [NUM_IN-1:0] term_vec;

  always_comb begin
    case (paddr)
      `LCG3_GATE3_OFS: sel_reg = LCG3_REG_GATE3;
      `LCG3_MIRROR_OFS: sel_reg = LCG3_REG_MIRROR;
      default: sel_reg = LCG3_REG_NONE;
    endcase
  end

  assign setup_ph = psel & ~penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign access_wr = psel & penable & pwrite & pready;
  // Unmapped offsets answer with an error; a write to the mirror does not
  assign pslverr = psel & penable & (sel_reg == LCG3_REG_NONE);

  // --------------------------------------------------------------------
  // Gate 3 term select register
  // --------------------------------------------------------------------
  // Only power-on or brown-out loads it; nrst alone leaves it alone
  always_ff @(posedge clk) begin
    if (!por_bor_nrst) begin
      gate3_terms_r <= `LCG3_GATE3_POR_VAL;
    end else if (access_wr && sel_reg == LCG3_REG_GATE3 && pstrb[0]) begin
      gate3_terms_r <= pwdata[7:0];
    end
  end

  assign cell_gate3_terms = gate3_terms_r;

  // --------------------------------------------------------------------
  // Mirror register
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || !por_bor_nrst) begin
      mirror_r <= `LCG3_MIRROR_RST_VAL;
    end else begin
      mirror_r <= {cell4_out, cell3_out, cell2_out, cell1_out};
    end
  end

  assign mirror_cell1_out = mirror_r[0];
  assign mirror_cell2_out = mirror_r[1];
  assign mirror_cell3_out = mirror_r[2];
  assign mirror_cell4_out = mirror_r[3];

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Captured in the setup cycle so prdata is a flop in the access cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      case (sel_reg)
        LCG3_REG_GATE3: prdata_r <= {24'h00_0000, gate3_terms_r};
        LCG3_REG_MIRROR: prdata_r <= {28'h000_0000, mirror_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_r;

  // --------------------------------------------------------------------
  // Gate 3 terms and combiner
  // --------------------------------------------------------------------
  assign data_vec = {cell_data_in_d, cell_data_in_c, cell_data_in_b,
                     cell_data_in_a};

  // Select bit pairs sit at 2i+1 (true) and 2i (inverted) for input i
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_term
      lcg3_term_sel u_term (
        .data_in(data_vec[gi]),
        .true_sel(gate3_terms_r[2*gi+1]),
        .inv_sel(gate3_terms_r[2*gi]),
        .term(term_vec[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gate3_r <= 1'b0;
    end else begin
      gate3_r <= |term_vec;
    end
  end

  assign gate3_out = gate3_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Sampled nrst sits in the antecedent: the disable sees the live
  // reset, which lets go one edge before the gate flop does
  AST_IN4_TERM: assert property (
    (nrst && ((gate3_terms_r[`LCG3_IN4_TRUE_BIT] && cell_data_in_d) ||
     (gate3_terms_r[`LCG3_IN4_INV_BIT] && !cell_data_in_d)))
    |=> gate3_out)
    else $error("Input d term not gated into gate 3");

  AST_IN3_TERM: assert property (
    (nrst && ((gate3_terms_r[`LCG3_IN3_TRUE_BIT] && cell_data_in_c) ||
     (gate3_terms_r[`LCG3_IN3_INV_BIT] && !cell_data_in_c)))
    |=> gate3_out)
    else $error("Input c term not gated into gate 3");

  AST_IN2_TERM: assert property (
    (nrst && ((gate3_terms_r[`LCG3_IN2_TRUE_BIT] && cell_data_in_b) ||
     (gate3_terms_r[`LCG3_IN2_INV_BIT] && !cell_data_in_b)))
    |=> gate3_out)
    else $error("Input b term not gated into gate 3");

  AST_IN1_TERM: assert property (
    (nrst && ((gate3_terms_r[`LCG3_IN1_TRUE_BIT] && cell_data_in_a) ||
     (gate3_terms_r[`LCG3_IN1_INV_BIT] && !cell_data_in_a)))
    |=> gate3_out)
    else $error("Input a term not gated into gate 3");

  AST_IN4_EXCLUDED: assert property (
    (nrst && gate3_terms_r[5:0] == 6'h00 &&
     !(gate3_terms_r[`LCG3_IN4_TRUE_BIT] && cell_data_in_d) &&
     !(gate3_terms_r[`LCG3_IN4_INV_BIT] && !cell_data_in_d))
    |=> !gate3_out)
    else $error("Input d term gated in while not selected");

  AST_IN3_EXCLUDED: assert property (
    (nrst && gate3_terms_r[7:6] == 2'h0 && gate3_terms_r[3:0] == 4'h0 &&
     !(gate3_terms_r[`LCG3_IN3_TRUE_BIT] && cell_data_in_c) &&
     !(gate3_terms_r[`LCG3_IN3_INV_BIT] && !cell_data_in_c))
    |=> !gate3_out)
    else $error("Input c term gated in while not selected");

  AST_IN2_EXCLUDED: assert property (
    (nrst && gate3_terms_r[7:4] == 4'h0 && gate3_terms_r[1:0] == 2'h0 &&
     !(gate3_terms_r[`LCG3_IN2_TRUE_BIT] && cell_data_in_b) &&
     !(gate3_terms_r[`LCG3_IN2_INV_BIT] && !cell_data_in_b))
    |=> !gate3_out)
    else $error("Input b term gated in while not selected");

  AST_IN1_EXCLUDED: assert property (
    (nrst && gate3_terms_r[7:2] == 6'h00 &&
     !(gate3_terms_r[`LCG3_IN1_TRUE_BIT] && cell_data_in_a) &&
     !(gate3_terms_r[`LCG3_IN1_INV_BIT] && !cell_data_in_a))
    |=> !gate3_out)
    else $error("Input a term gated in while not selected");

  AST_GATE3_RESET: assert property (
    disable iff (1'b0)
    !nrst |=> !gate3_out)
    else $error("Gate 3 not low after reset");

  AST_GATE3_ONLY_TERMS: assert property (
    gate3_out |-> $past(
      (gate3_terms_r[7] && cell_data_in_d) ||
      (gate3_terms_r[6] && !cell_data_in_d) ||
      (gate3_terms_r[5] && cell_data_in_c) ||
      (gate3_terms_r[4] && !cell_data_in_c) ||
      (gate3_terms_r[3] && cell_data_in_b) ||
      (gate3_terms_r[2] && !cell_data_in_b) ||
      (gate3_terms_r[1] && cell_data_in_a) ||
      (gate3_terms_r[0] && !cell_data_in_a)))
    else $error("Gate 3 high with no enabled term true");

  AST_GATE3_NONE_LOW: assert property (
    (gate3_terms_r == 8'h00) [*2] |-> !gate3_out)
    else $error("Gate 3 not low with all terms disabled");

  AST_SEL_WRITE: assert property (
    disable iff (!por_bor_nrst)
    (access_wr && sel_reg == LCG3_REG_GATE3 && pstrb[0])
    |=> gate3_terms_r == $past(pwdata[7:0]))
    else $error("Gate 3 select write not stored");

  AST_SEL_READBACK: assert property (
    (setup_ph && !pwrite && sel_reg == LCG3_REG_GATE3)
    ##1 (psel && penable) |-> prdata == {24'h00_0000, $past(gate3_terms_r)})
    else $error("Gate 3 select read back wrong");

  AST_SEL_POR_LOAD: assert property (
    disable iff (1'b0)
    !por_bor_nrst |=> gate3_terms_r == `LCG3_GATE3_POR_VAL)
    else $error("Gate 3 select not loaded by power-on reset");

  AST_SEL_UNMAPPED_KEEP: assert property (
    disable iff (!por_bor_nrst)
    (access_wr && sel_reg == LCG3_REG_NONE)
    |=> $stable(gate3_terms_r))
    else $error("Unmapped write changed gate 3 select");

  AST_SEL_KEEP_RESET: assert property (
    disable iff (!por_bor_nrst)
    !nrst |=> $stable(gate3_terms_r))
    else $error("Gate 3 select changed by a non power-on reset");

  AST_MIRROR_COPY: assert property (
    nrst |=> mirror_r == $past({cell4_out, cell3_out, cell2_out,
                                cell1_out}))
    else $error("Mirror does not follow cell outputs");

  AST_MIRROR_RESET: assert property (
    disable iff (1'b0)
    !nrst |=> mirror_r == 4'h0)
    else $error("Mirror not cleared by reset");

  AST_MIRROR_READBACK: assert property (
    (setup_ph && !pwrite && sel_reg == LCG3_REG_MIRROR)
    ##1 (psel && penable) |-> prdata == {28'h000_0000, $past(mirror_r)})
    else $error("Mirror read back wrong");

  AST_MIRROR_UPPER_ZERO: assert property (
    (psel && penable && sel_reg == LCG3_REG_MIRROR)
    |-> prdata[31:4] == 28'h000_0000 && !pslverr)
    else $error("Mirror upper bits not zero or access refused");

  AST_MIRROR_WRITE_IGNORED: assert property (
    (access_wr && sel_reg == LCG3_REG_MIRROR)
    |=> mirror_r == $past({cell4_out, cell3_out, cell2_out, cell1_out}))
    else $error("Mirror write had an effect");

  COV_SEL_WRITE: cover property (
    access_wr && sel_reg == LCG3_REG_GATE3 && pstrb[0]);

  COV_GATE3_RISE: cover property ($rose(gate3_out));

  COV_MIRROR_READ: cover property (
    psel && penable && !pwrite && sel_reg == LCG3_REG_MIRROR &&
    prdata[3:0] != 4'h0);

  COV_UNMAPPED: cover property (pslverr);

  COV_WARM_RESET: cover property (
    disable iff (1'b0) por_bor_nrst && !nrst ##1 nrst);

endmodule : lcg3_top

// *** core/lcg3_regs.svh ***
/*
 * Register offsets, field positions and reset values of the gate 3
 * term select and cell output mirror block.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef LCG3_REGS_SVH
`define LCG3_REGS_SVH

// ----------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------
`define LCG3_GATE3_OFS 12'h000
`define LCG3_MIRROR_OFS 12'h004

// ----------------------------------------------------------------------
// Gate 3 term select fields
// ----------------------------------------------------------------------
`define LCG3_IN4_TRUE_BIT 7
`define LCG3_IN4_INV_BIT 6
`define LCG3_IN3_TRUE_BIT 5
`define LCG3_IN3_INV_BIT 4
`define LCG3_IN2_TRUE_BIT 3
`define LCG3_IN2_INV_BIT 2
`define LCG3_IN1_TRUE_BIT 1
`define LCG3_IN1_INV_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LCG3_GATE3_POR_VAL 8'h00
`define LCG3_MIRROR_RST_VAL 4'h0

`endif

// *** core/lcg3_pkg.sv ***
/*
 * Types shared by the gate 3 term select and mirror block.
 * Assumes nothing of its surroundings.
 */
package lcg3_pkg;

  typedef logic [11:0] lcg3_addr_t;
  typedef logic [31:0] lcg3_data_t;

  typedef enum logic [1:0] {
    LCG3_REG_GATE3 = 2'b00,
    LCG3_REG_MIRROR = 2'b01,
    LCG3_REG_NONE = 2'b10
  } lcg3_reg_e;

endpackage : lcg3_pkg

// *** core/lcg3_term_sel.sv ***
/*
 * One data input of a gate: its true and inverted terms, each enabled
 * by its own select bit, merged into one term.
 * Assumes the select bits are stable register outputs.
 */
`timescale 1ns/1ps
module lcg3_term_sel (
  input wire logic data_in,
  input wire logic true_sel,
  input wire logic inv_sel,
  output logic term
);

  // Both selects set gives a constant high term, as an OR of x and ~x
  assign term = (true_sel & data_in) | (inv_sel & ~data_in);

endmodule : lcg3_term_sel

// *** test/lcg3_top_tb_top.sv ***
/*
 * Self-checking bench for the gate 3 term select and mirror block.
 * Assumes the core header, package and top module are compiled first.
 */
`timescale 1ns/1ps
`include "lcg3_regs.svh"
module lcg3_top_tb_top;
  import lcg3_pkg::*;
  logic clk, nrst, por_bor_nrst, psel, penable, pwrite;
  lcg3_addr_t paddr;
  lcg3_data_t pwdata, prdata, rd;
  logic [3:0] pstrb, din, cells, mirror;
  logic pready, pslverr, err, gate3_out;
  logic [7:0] cell_gate3_terms;
  int miscompares, num_checks, cycles;
  // Rows: select value, inputs {d,c,b,a}, gate 3 result in the last digit
  logic [15:0] rows [21] = '{16'h8081, 16'h8070, 16'h4001, 16'h4080,
    16'h2041, 16'h20B0, 16'h1001, 16'h1040, 16'h0821, 16'h08D0,
    16'h0401, 16'h0420, 16'h0211, 16'h02E0, 16'h0101, 16'h0110,
    16'h00F0, 16'h0000, 16'hAA00, 16'hAA41, 16'hC0F1};

  lcg3_top i_dut (.clk(clk), .nrst(nrst), .por_bor_nrst(por_bor_nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_data_in_a(din[0]), .cell_data_in_b(din[1]),
    .cell_data_in_c(din[2]), .cell_data_in_d(din[3]),
    .cell1_out(cells[0]), .cell2_out(cells[1]), .cell3_out(cells[2]),
    .cell4_out(cells[3]), .gate3_out(gate3_out),
    .cell_gate3_terms(cell_gate3_terms), .mirror_cell1_out(mirror[0]),
    .mirror_cell2_out(mirror[1]), .mirror_cell3_out(mirror[2]),
    .mirror_cell4_out(mirror[3]));

  // --------------------------------------------------------------------
  // Clock, timeout and helpers
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task stop_test;
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Entered just after a rising edge; returns one edge after release
  task apb(input logic wr, input lcg3_addr_t a, input lcg3_data_t wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    por_bor_nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    din = 4'h0;
    cells = 4'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    por_bor_nrst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(32'(cell_gate3_terms), 32'h0000_0000);
    chk(32'(mirror), 32'h0000_0000);
    chk(32'(pready), 32'h0000_0001);
    @(posedge clk);
    foreach (rows[i]) begin
      apb(1'b1, `LCG3_GATE3_OFS, {24'h00_0000, rows[i][15:8]});
      din <= rows[i][7:4];
      @(posedge clk);
      @(negedge clk);
      chk(32'(gate3_out), 32'(rows[i][0]));
      @(posedge clk);
      apb(1'b0, `LCG3_GATE3_OFS, 32'h0000_0000);
      chk(rd, {24'h00_0000, rows[i][15:8]});
    end
    // Mirror follows the cell outputs; its upper half ignores writes
    cells <= 4'hA;
    @(posedge clk);
    @(negedge clk);
    chk(32'(mirror), 32'h0000_000A);
    @(posedge clk);
    apb(1'b1, `LCG3_MIRROR_OFS, 32'hFFFF_FFF5);
    chk(32'(err), 32'h0000_0000);
    apb(1'b0, `LCG3_MIRROR_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    // Masked byte lane and unmapped address must leave select alone
    apb(1'b1, `LCG3_GATE3_OFS, 32'h0000_005A);
    pstrb <= 4'hE;
    apb(1'b1, `LCG3_GATE3_OFS, 32'h0000_00FF);
    pstrb <= 4'hF;
    apb(1'b1, 12'h008, 32'h0000_00FF);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(cell_gate3_terms), 32'h0000_005A);
    // Ordinary reset keeps the select bits, power-on reset loads them
    cells <= 4'hF;
    nrst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(32'(mirror), 32'h0000_0000);
    chk(32'(gate3_out), 32'h0000_0000);
    chk(32'(cell_gate3_terms), 32'h0000_005A);
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(32'(mirror), 32'h0000_000F);
    @(posedge clk);
    nrst <= 1'b0;
    por_bor_nrst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(32'(cell_gate3_terms), 32'h0000_0000);
    @(posedge clk);
    nrst <= 1'b1;
    por_bor_nrst <= 1'b1;
    @(posedge clk);
    stop_test();
  end
endmodule : lcg3_top_tb_top
